// ### design/qsp_consts.vh
// constants for the queued serial port status and flag block
// assumes inclusion by bare name from the design files
`ifndef QSP_CONSTS_VH
`define QSP_CONSTS_VH
`define QSP_ADDR_STATUS 4'h0
`define QSP_ADDR_CTRL 4'h4
`define QSP_ADDR_REQ 4'h8
`define QSP_ADDR_EVENT 4'hC
`define QSP_BIT_TCF 31
`define QSP_BIT_RUN 30
`define QSP_BIT_EOQ 28
`define QSP_BIT_TUF 27
`define QSP_BIT_TFF 25
`define QSP_BIT_ROF 19
`define QSP_BIT_RDF 17
`define QSP_CTRL_START 0
`define QSP_CTRL_STOP 1
`define QSP_CTRL_MODULE_DISABLE_BIT 2
`define QSP_CTRL_SLAVE 3
`define QSP_CTRL_MODULE_DISABLE_BIT_RST 1'b1
`define QSP_CTRL_SLAVE_RST 1'b0
`define QSP_REQ_TFF_DIRS 24
`define QSP_REQ_RDF_DIRS 16
`define QSP_REQ_MASK 32'h9B0B0000
`define QSP_W1C_MASK 32'h9A0A0000
`endif

// ### design/qsp_sync.v
// two-flop synchroniser for a level arriving from outside the clock domain
// assumes the input is a plain level; first flop is read only by the second
`timescale 1ns/1ps
module qsp_sync (
   input wire clk,
   input wire rstn,
   input wire d,
   output wire q
);
   reg meta_r;
   reg sync_r;
   // first stage feeds only the second stage
   always @(posedge clk) begin
      if (!rstn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end
   assign q = sync_r;
endmodule

// ### design/qsp_flag.v
// one sticky event flag: set by hardware, cleared by write-one or acknowledge
// assumes set, clear and ack arrive on the same clock; set may be a pulse or a held level
`timescale 1ns/1ps
module qsp_flag (
   input wire clk,
   input wire rstn,
   input wire set,
   input wire clr,
   output wire q
);
   reg flag_r;
   // set wins over clear so an event in the clearing cycle is kept
   always @(posedge clk) begin
      if (!rstn)
         flag_r <= 1'b0;
      else if (set)
         flag_r <= 1'b1;
      else if (clr)
         flag_r <= 1'b0;
   end
   assign q = flag_r;
endmodule

// ### design/qsp_status.v
// status and event flag logic of the queued serial port, with an ahb-lite slave
// assumes frame events come from the shifter on clk; sck and chip select come
// from pins and are synchronised here
// limitation: hsize is ignored, every access is taken as one whole word
`timescale 1ns/1ps
`include "qsp_consts.vh"
// How it works
// - writing one clears a flag, zero ignored
// - frame done set at last sampled bit
// - run bit shows stopped or running state
// - queue end set on tagged last bit
// - queue end set clears run bit
// - queue end disabled in slave mode
// - slave underflow when master starts, fifo empty
// - fill request set while tx not full and enabled
// - fill cleared by write or ack when full
// - overflow when rx and shifter full at start
// - drain request set while rx nonempty
// - drain cleared by write or ack when empty
// - flags drive interrupt or dma requests
module qsp_status (
   input wire clk,
   input wire rstn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire link_sck,
   input wire link_cs_n,
   input wire last_bit_sampled,
   input wire cmd_queue_end,
   input wire tx_fifo_empty,
   input wire tx_fifo_full,
   input wire rx_fifo_empty,
   input wire rx_fifo_full,
   input wire shift_full,
   input wire master_start,
   input wire dma_tx_ack,
   input wire dma_rx_ack,
   output wire run_state,
   output wire module_disable,
   output wire slave_mode,
   output wire irq,
   output wire dma_tx_req,
   output wire dma_rx_req,
   output wire sck_rise,
   output wire sck_fall
);
   ////////////////////////////////////////////////////////////////////////
   // run state machine, one-hot
   localparam ST_STOP = 2'b01;
   localparam ST_RUN = 2'b10;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg module_disable_bit_r;
   reg slave_r;
   reg [31:0] req_r;
   reg [31:0] rdata_r;
   reg sck_d_r;
   reg cs_d_r;
   reg wr_pend_r;
   reg [3:0] wr_addr_r;
   reg frame_sel_r;
   wire sck_s;
   wire cs_n_s;
   wire cs_fall;
   wire ext_start;
   wire xfer_start;
   wire wr_stat;
   wire wr_ctrl;
   wire [31:0] w1c;
   wire [31:0] status;
   wire f_tcf;
   wire f_eoq;
   wire f_tuf;
   wire f_tff;
   wire f_rof;
   wire f_rdf;
   wire eoq_set;
   wire addr_ph;
   wire wr_req;
   wire tff_en;
   wire rdf_en;
   wire irq_tcf;
   wire irq_eoq;
   wire irq_tuf;
   wire irq_rof;
   wire irq_tff;
   wire irq_rdf;

   // pick the word address out of a byte address
   function [3:0] word_addr;
      input [31:0] a;
      begin
         word_addr = {a[3:2], 2'b00};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; only the second stage is used below
   qsp_sync u_sync_sck (
      .clk(clk),
      .rstn(rstn),
      .d(link_sck),
      .q(sck_s)
   );
   qsp_sync u_sync_cs (
      .clk(clk),
      .rstn(rstn),
      .d(link_cs_n),
      .q(cs_n_s)
   );

   // edge finders run on the synchronised copies
   // both reset to the synchroniser's reset level, so release makes no false edge
   always @(posedge clk) begin
      if (!rstn) begin
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b0;
      end else begin
         sck_d_r <= sck_s;
         cs_d_r <= cs_n_s;
      end
   end
   assign sck_rise = sck_s & ~sck_d_r;
   assign sck_fall = ~sck_s & sck_d_r;
   assign cs_fall = cs_d_r & ~cs_n_s;
   // an external master starts a frame when chip select falls in slave mode
   assign ext_start = slave_r & cs_fall;
   assign xfer_start = slave_r ? ext_start : master_start;

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait states, writes land in the data phase
   // read data is captured at the address edge and stands until the next read
   assign addr_ph = hsel & hready & htrans[1];
   always @(posedge clk) begin
      if (!rstn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 4'h0;
         rdata_r <= 32'h00000000;
      end else begin
         wr_pend_r <= addr_ph & hwrite;
         wr_addr_r <= word_addr(haddr);
         if (addr_ph & ~hwrite) begin
            case (word_addr(haddr))
               `QSP_ADDR_STATUS: rdata_r <= status;
               `QSP_ADDR_CTRL: rdata_r <= {28'h0000000, slave_r, module_disable_bit_r, 2'b00};
               `QSP_ADDR_REQ: rdata_r <= req_r;
               default: rdata_r <= 32'h00000000;
            endcase
         end
      end
   end
   assign hrdata = rdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_stat = wr_pend_r & (wr_addr_r == `QSP_ADDR_STATUS);
   assign wr_ctrl = wr_pend_r & (wr_addr_r == `QSP_ADDR_CTRL);
   assign wr_req = wr_pend_r & (wr_addr_r == `QSP_ADDR_REQ);
   // reserved bits are masked off, so a stray one there does nothing
   assign w1c = wr_stat ? (hwdata & `QSP_W1C_MASK) : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // control and request-enable registers
   always @(posedge clk) begin
      if (!rstn) begin
         module_disable_bit_r <= `QSP_CTRL_MODULE_DISABLE_BIT_RST;
         slave_r <= `QSP_CTRL_SLAVE_RST;
         req_r <= 32'h00000000;
      end else begin
         if (wr_ctrl) begin
            module_disable_bit_r <= hwdata[`QSP_CTRL_MODULE_DISABLE_BIT];
            slave_r <= hwdata[`QSP_CTRL_SLAVE];
         end
         if (wr_req)
            req_r <= hwdata & `QSP_REQ_MASK;
      end
   end
   assign module_disable = module_disable_bit_r;
   assign slave_mode = slave_r;

   ////////////////////////////////////////////////////////////////////////
   // run state: start/stop commands, queue end forces stop
   // queue end is checked first, so a stop written in the same cycle changes nothing
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_STOP: begin
            if (wr_ctrl & hwdata[`QSP_CTRL_START] & ~hwdata[`QSP_CTRL_MODULE_DISABLE_BIT])
               state_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (eoq_set)
               state_nxt = ST_STOP;
            else if (wr_ctrl & (hwdata[`QSP_CTRL_STOP] | hwdata[`QSP_CTRL_MODULE_DISABLE_BIT]))
               state_nxt = ST_STOP;
         end
         default: state_nxt = ST_STOP;
      endcase
   end
   always @(posedge clk) begin
      if (!rstn)
         state_r <= ST_STOP;
      else
         state_r <= state_nxt;
   end
   assign run_state = state_r[1];

   ////////////////////////////////////////////////////////////////////////
   // frame tag: remembers which mode the current frame started in
   // a switch to slave mode during a frame still blocks that frame's queue end
   always @(posedge clk) begin
      if (!rstn)
         frame_sel_r <= 1'b0;
      else if (xfer_start)
         frame_sel_r <= slave_r;
   end
   // queue end only counts for master frames
   assign eoq_set = last_bit_sampled & cmd_queue_end & ~slave_r & ~frame_sel_r;

   ////////////////////////////////////////////////////////////////////////
   // sticky event flags
   // frame done: one pulse per frame from the shifter
   qsp_flag u_tcf (
      .clk(clk),
      .rstn(rstn),
      .set(last_bit_sampled),
      .clr(w1c[`QSP_BIT_TCF]),
      .q(f_tcf)
   );

   // queue end: master frames only, see eoq_set
   qsp_flag u_eoq (
      .clk(clk),
      .rstn(rstn),
      .set(eoq_set),
      .clr(w1c[`QSP_BIT_EOQ]),
      .q(f_eoq)
   );

   // underflow: an outside master selects us with nothing queued
   qsp_flag u_tuf (
      .clk(clk),
      .rstn(rstn),
      .set(ext_start & tx_fifo_empty),
      .clr(w1c[`QSP_BIT_TUF]),
      .q(f_tuf)
   );

   // overflow: a new frame starts with nowhere to put its data
   qsp_flag u_rof (
      .clk(clk),
      .rstn(rstn),
      .set(xfer_start & rx_fifo_full & shift_full),
      .clr(w1c[`QSP_BIT_ROF]),
      .q(f_rof)
   );

   // fill request: level-set while not full and enabled
   // a write-one clear only sticks once the fifo is full or the module is disabled, since set wins
   qsp_flag u_tff (
      .clk(clk),
      .rstn(rstn),
      .set(~tx_fifo_full & ~module_disable_bit_r),
      .clr(w1c[`QSP_BIT_TFF] | (dma_tx_ack & tx_fifo_full)),
      .q(f_tff)
   );

   // drain request: level-set while rx holds data
   // likewise a clear only sticks once the fifo is empty
   qsp_flag u_rdf (
      .clk(clk),
      .rstn(rstn),
      .set(~rx_fifo_empty),
      .clr(w1c[`QSP_BIT_RDF] | (dma_rx_ack & rx_fifo_empty)),
      .q(f_rdf)
   );

   // reserved positions always read as zero
   assign status = {f_tcf, run_state, 1'b0, f_eoq, f_tuf, 1'b0, f_tff, 5'h00,
                    f_rof, 1'b0, f_rdf, 17'h00000};

   ////////////////////////////////////////////////////////////////////////
   // request routing: enables gate flags, select picks interrupt or dma
   // a flag only raises a request while its enable bit is set
   assign tff_en = f_tff & req_r[`QSP_BIT_TFF];
   assign rdf_en = f_rdf & req_r[`QSP_BIT_RDF];
   // fill and drain go to dma when their select bit is set
   assign dma_tx_req = tff_en & req_r[`QSP_REQ_TFF_DIRS];
   assign dma_rx_req = rdf_en & req_r[`QSP_REQ_RDF_DIRS];
   // every other enabled source, and unselected fill or drain, is an interrupt
   assign irq_tcf = f_tcf & req_r[`QSP_BIT_TCF];
   assign irq_eoq = f_eoq & req_r[`QSP_BIT_EOQ];
   assign irq_tuf = f_tuf & req_r[`QSP_BIT_TUF];
   assign irq_rof = f_rof & req_r[`QSP_BIT_ROF];
   assign irq_tff = tff_en & ~req_r[`QSP_REQ_TFF_DIRS];
   assign irq_rdf = rdf_en & ~req_r[`QSP_REQ_RDF_DIRS];
   assign irq = irq_tcf | irq_eoq | irq_tuf | irq_rof | irq_tff | irq_rdf;
endmodule

// ### dv/qsp_status_assertions.sv
// checker for the status block: flag, request and run-state relations
// assumes one clk domain, sync active-low rstn, hwrite held through data phase
`timescale 1ns/1ps
module qsp_chk (
   input wire clk,
   input wire rstn,
   input wire hwrite,
   input wire last_bit_sampled,
   input wire cmd_queue_end,
   input wire tx_fifo_full,
   input wire rx_fifo_empty,
   input wire dma_tx_ack,
   input wire dma_rx_ack,
   input wire run_state,
   input wire module_disable,
   input wire slave_mode,
   input wire dma_tx_req,
   input wire dma_rx_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////////
   // no write in flight, so only hardware events may move the outputs
   qend_stop_a: assert property (last_bit_sampled && cmd_queue_end && !slave_mode |=> !run_state)
      else $error("run kept after queue end");
   slave_qend_a: assert property (slave_mode && last_bit_sampled && cmd_queue_end && run_state
      && !hwrite |=> run_state) else $error("queue end acted in slave mode");
   run_start_a: assert property ($rose(run_state) |-> $past(hwrite))
      else $error("run rose without a write");
   module_disable_bit_write_a: assert property ($changed(module_disable) |-> $past(hwrite))
      else $error("disable moved without a write");
   tx_ack_clr_a: assert property (dma_tx_ack && tx_fifo_full |=> !dma_tx_req)
      else $error("fill request kept after ack");
   rx_ack_clr_a: assert property (dma_rx_ack && rx_fifo_empty |=> !dma_rx_req)
      else $error("drain request kept after ack");
   tx_fill_hold_a: assert property (dma_tx_req && !tx_fifo_full && !module_disable && !hwrite
      |=> dma_tx_req) else $error("fill request dropped while not full");
   rx_drain_hold_a: assert property (dma_rx_req && !rx_fifo_empty && !hwrite |=> dma_rx_req)
      else $error("drain request dropped while not empty");
   cover property (last_bit_sampled && cmd_queue_end && run_state);
   cover property (dma_rx_ack && rx_fifo_empty);
   cover property (dma_tx_ack && tx_fifo_full);
endmodule
bind qsp_status qsp_chk i_qsp_chk (.clk, .rstn, .hwrite, .last_bit_sampled, .cmd_queue_end,
   .tx_fifo_full, .rx_fifo_empty, .dma_tx_ack, .dma_rx_ack, .run_state, .module_disable,
   .slave_mode, .dma_tx_req, .dma_rx_req);

// ### dv/qsp_ext_master.sv
// model of an external spi master driving the clock and select pins
// assumes the bench calls frame while the block is in slave mode
`timescale 1ns/1ps
module qsp_ext_master (
   output reg sck,
   output reg cs_n
);
   // idle: select high, clock parked low outside frames
   initial begin
      sck = 1'h0;
      cs_n = 1'h1;
   end
   // eight clocks of 125 ns; offset keeps pin edges away from clk edges
   task frame;
      begin
         #3 cs_n = 1'h0;
         repeat (8) begin
            #62.5 sck = 1'h1;
            #62.5 sck = 1'h0;
         end
         #62.5 cs_n = 1'h1;
      end
   endtask
endmodule

// ### dv/tb_top.sv
// self-checking bench for the status and flag block
// assumes zero-wait bus answers and registered read data
`timescale 1ns/1ps
`include "qsp_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
   reg clk = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   reg [31:0] haddr = 32'h0, hwdata = 32'h0, rdat;
   reg [1:0] htrans = 2'h0;
   reg lbs = 1'h0, cqe = 1'h0, mst = 1'h0, txa = 1'h0, rxa = 1'h0;
   reg txe = 1'h0, txf = 1'h0, rxe = 1'h1, rxf = 1'h0, shf = 1'h0;
   integer err_count = 0, compares = 0, cyc = 0, n_rise = 0, n_fall = 0;
   wire hresp_w, module_disable_bit_w, slave_w, rise_w, fall_w;
   wire [31:0] hrdata;
   wire hreadyout, run_state, sck, cs_n, irq, dma_tx_req, dma_rx_req;
   always #5 clk = ~clk;
   qsp_ext_master i_qsp_ext_master (.sck(sck), .cs_n(cs_n));
   qsp_status i_qsp_status (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp_w), .link_sck(sck),
      .link_cs_n(cs_n),
      .last_bit_sampled(lbs), .cmd_queue_end(cqe), .tx_fifo_empty(txe), .tx_fifo_full(txf),
      .rx_fifo_empty(rxe), .rx_fifo_full(rxf), .shift_full(shf), .master_start(mst),
      .dma_tx_ack(txa), .dma_rx_ack(rxa), .run_state(run_state), .module_disable(module_disable_bit_w),
      .slave_mode(slave_w), .irq(irq), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req),
      .sck_rise(rise_w), .sck_fall(fall_w));
   ////////////////////////////////////////////////////////////////////////////////
   function [31:0] bm(input integer n);
      bm = 32'h1 << n;
   endfunction
   // one single transfer; write data held until the data phase completes
   task bus(input [3:0] a, input w, input [31:0] d);
      begin
         @(posedge clk);
         hsel <= 1'h1;
         htrans <= 2'h2;
         haddr <= {28'h0, a};
         hwrite <= w;
         @(posedge clk);
         while (!hreadyout) @(posedge clk);
         htrans <= 2'h0;
         hwdata <= d;
         @(posedge clk);
         while (!hreadyout) @(posedge clk);
         rdat = hrdata;
         hsel <= 1'h0;
         hwrite <= 1'h0;
      end
   endtask
   task st(input [31:0] m, input [31:0] e);
      begin
         bus(`QSP_ADDR_STATUS, 1'h0, 32'h0);
         `CHK(rdat & m, e)
      end
   endtask
   // one-cycle pulses: rx ack, tx ack, start, queue end, last bit
   task ev(input [4:0] v);
      begin
         @(posedge clk);
         {rxa, txa, mst, cqe, lbs} <= v;
         @(posedge clk);
         {rxa, txa, mst, cqe, lbs} <= 5'h0;
         @(negedge clk);
      end
   endtask
   task results;
      begin
         $display("errors %0d compares %0d", err_count, compares);
         if (err_count == 0 && compares > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // cut a hang short; the sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (rise_w === 1'h1) n_rise = n_rise + 1; // link clock edges seen by the block
      if (fall_w === 1'h1) n_fall = n_fall + 1;
      if (cyc == 5000) begin
         err_count++;
         results;
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'h1;
      st(32'hFFFFFFFF, 32'h0);
      `CHK(module_disable_bit_w, 1'h1)
      bus(`QSP_ADDR_CTRL, 1'h0, 32'h0);
      `CHK(rdat, 32'h4)
      `CHK(hresp_w, 1'h0)
      bus(`QSP_ADDR_CTRL, 1'h1, 32'h0);
      st(bm(`QSP_BIT_TFF), bm(`QSP_BIT_TFF));
      `CHK(module_disable_bit_w, 1'h0)
      txf <= 1'h1;
      bus(`QSP_ADDR_STATUS, 1'h1, 32'h0);
      st(bm(`QSP_BIT_TFF), bm(`QSP_BIT_TFF));
      bus(`QSP_ADDR_STATUS, 1'h1, bm(`QSP_BIT_TFF));
      st(bm(`QSP_BIT_TFF), 32'h0);
      ev(5'h01);
      st(bm(`QSP_BIT_TCF), bm(`QSP_BIT_TCF));
      bus(`QSP_ADDR_STATUS, 1'h1, bm(`QSP_BIT_TCF));
      st(bm(`QSP_BIT_TCF), 32'h0);
      bus(`QSP_ADDR_CTRL, 1'h1, 32'h1);
      st(bm(`QSP_BIT_RUN), bm(`QSP_BIT_RUN));
      ev(5'h03);
      st(bm(`QSP_BIT_RUN) | bm(`QSP_BIT_EOQ), bm(`QSP_BIT_EOQ));
      `CHK(run_state, 1'h0)
      rxf <= 1'h1;
      shf <= 1'h1;
      ev(5'h04);
      st(bm(`QSP_BIT_ROF), bm(`QSP_BIT_ROF));
      rxe <= 1'h0;
      st(bm(`QSP_BIT_RDF), bm(`QSP_BIT_RDF));
      bus(`QSP_ADDR_REQ, 1'h1, 32'h03030000);
      bus(`QSP_ADDR_REQ, 1'h0, 32'h0);
      `CHK(rdat, 32'h03030000)
      @(negedge clk);
      `CHK(dma_rx_req, 1'h1)
      rxe <= 1'h1;
      ev(5'h10);
      st(bm(`QSP_BIT_RDF), 32'h0);
      rxe <= 1'h0;
      st(bm(`QSP_BIT_RDF), bm(`QSP_BIT_RDF));
      rxe <= 1'h1;
      bus(`QSP_ADDR_STATUS, 1'h1, bm(`QSP_BIT_RDF));
      st(bm(`QSP_BIT_RDF), 32'h0);
      txf <= 1'h0;
      @(posedge clk);
      txf <= 1'h1;
      @(negedge clk);
      `CHK(dma_tx_req, 1'h1)
      ev(5'h08);
      `CHK(dma_tx_req, 1'h0)
      bus(`QSP_ADDR_STATUS, 1'h1, `QSP_W1C_MASK);
      bus(`QSP_ADDR_CTRL, 1'h1, 32'h9);
      ev(5'h03);
      st(bm(`QSP_BIT_EOQ), 32'h0);
      `CHK(run_state, 1'h1)
      `CHK(slave_w, 1'h1)
      bus(`QSP_ADDR_CTRL, 1'h1, 32'hA);
      @(negedge clk);
      `CHK(run_state, 1'h0)
      bus(`QSP_ADDR_REQ, 1'h1, bm(`QSP_BIT_TCF));
      ev(5'h01);
      `CHK(irq, 1'h1)
      txe <= 1'h1;
      @(posedge clk);
      i_qsp_ext_master.frame();
      repeat (5) @(posedge clk);
      st(bm(`QSP_BIT_TUF), bm(`QSP_BIT_TUF));
      `CHK(n_rise, 8)
      `CHK(n_fall, 8)
      results;
   end
endmodule
